/* File: src/rsw_pkg.sv */
// Behaviour
// R1: status bits 31, 14, 9:8 and 0 always read zero.
// R2: bit 30 set when the frame failed the destination address filter.
// R3: bits 29:16 hold the received frame byte count.
// R4: bit 15 is the OR of bits 11, 7, 6 and 1.
// R5: bit 13 set when the destination address is broadcast.
// R6: bit 12 set when actual length disagrees with the length/type field.
// R7: bit 11 set when the frame ends before 64 bytes.
// R8: runt frames reach the host only when pass-bad-frames is set.
// R9: bit 10 set when the destination address is multicast.
// R10: bit 7 set above 1518 bytes; the frame is still received whole.
// R11: bit 6 set on a collision after the collision window.
// R12: bit 5 set when length/type exceeds 1500, never below 14 bytes.
// R13: bit 4 set when the frame runs past the watchdog limit.
// R14: bit 3 set when the receive error input rises during the frame.
// R15: bit 2 set for 4 dribble bits on MII, or 3 or more at 10 Mbps.
// R16: dribble is suppressed when the late collision bit is set.
// R17: bit 1 set on CRC mismatch or receive error during the frame.
// R18: host halts reception by clearing the receive enable bit.
// R19: one pulse on receiver_halted_pulse once reception has really stopped.
// R20: host may flush the FIFOs, then sets receive enable again.
// R21: error flag on data or status FIFO underrun, or status FIFO overrun.
// R22: after any receive FIFO underrun the host issues a soft reset.
package rsw_pkg;
  // status word field positions
  localparam int unsigned ST_FILTER_FAIL = 30;
  localparam int unsigned ST_LEN_LO = 16;
  localparam int unsigned ST_ERR_SUM = 15;
  localparam int unsigned ST_BCAST = 13;
  localparam int unsigned ST_LEN_MISMATCH = 12;
  localparam int unsigned ST_RUNT = 11;
  localparam int unsigned ST_MCAST = 10;
  localparam int unsigned ST_TOO_LONG = 7;
  localparam int unsigned ST_LATE_COL = 6;
  localparam int unsigned ST_ETH_TYPE = 5;
  localparam int unsigned ST_WDOG = 4;
  localparam int unsigned ST_MII_ERR = 3;
  localparam int unsigned ST_DRIBBLE = 2;
  localparam int unsigned ST_CRC_ERR = 1;
  localparam logic [31:0] ST_RESET = 32'h0000_0000;
  // frame size limits in bytes
  localparam int unsigned LEN_W = 14;
  localparam logic [13:0] COL_WINDOW = 14'h0040;
  localparam logic [13:0] MAX_FRAME = 14'h05ee;
  localparam logic [13:0] HDR_BYTES = 14'h000e;
  localparam logic [13:0] OVERHEAD = 14'h0012;
  localparam logic [15:0] MAX_LEN_FIELD = 16'h05dc;
  localparam logic [15:0] MIN_PAYLOAD = 16'h002e;
  localparam int unsigned WDOG_MIN = 2048;
  localparam int unsigned WDOG_MAX = 2560;
  // header byte positions
  localparam logic [13:0] DA_LAST = 14'h0005;
  localparam logic [13:0] LT_HI = 14'h000c;
  localparam logic [13:0] LT_LO = 14'h000d;
  // dribble thresholds and broadcast address byte
  localparam logic [2:0] DRIB_MII = 3'h4;
  localparam logic [2:0] DRIB_10M = 3'h3;
  localparam logic [7:0] BCAST_BYTE = 8'hff;
  typedef enum logic [1:0] {RSW_IDLE, RSW_RECV, RSW_PUSH, RSW_HALT} rsw_state_e;
endpackage

/* File: src/rsw_rx_status.sv */
`timescale 1ns/1ns
module rsw_rx_status
  import rsw_pkg::*;
#(
  parameter int unsigned WDOG_LIMIT = 2048
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // mac control register bits
  input wire logic receive_enable_bit,
  input wire logic pass_bad_frames,
  input wire logic mode_10m,
  // mac receive path
  input wire logic frm_start,
  input wire logic frm_byte_vld,
  input wire logic [7:0] frm_byte,
  input wire logic frm_end,
  input wire logic [2:0] frm_dribble_bits,
  input wire logic frm_crc_ok,
  input wire logic frm_filter_fail,
  input wire logic mii_rx_er,
  input wire logic mii_col,
  // receive fifo events
  input wire logic host_data_rd,
  input wire logic data_fifo_empty,
  input wire logic host_status_rd,
  input wire logic status_fifo_empty,
  input wire logic status_fifo_full,
  input wire logic error_flag_clr,
  // status push
  output logic [31:0] status_word_q,
  output logic status_push_q,
  // receiver state and errors
  output logic receiver_on_q,
  output logic receiver_halted_pulse_q,
  output logic receive_error_flag_q
);

  // ******************************************************************
  // elaboration checks
  // ******************************************************************
  generate
    if (WDOG_LIMIT < WDOG_MIN || WDOG_LIMIT > WDOG_MAX)
    begin : g_bad_wdog
      $error("watchdog limit outside 2048..2560 bytes");
    end
  endgenerate

  // range check above keeps the limit inside the 14-bit byte counter
  localparam logic [13:0] WDOG_CNT = WDOG_LIMIT[13:0];

  // ******************************************************************
  // state
  // ******************************************************************
  rsw_state_e state_q;
  rsw_state_e state_d;
  logic [13:0] cnt_q;
  logic [15:0] lt_q;
  logic da_bcast_q;
  logic da_mcast_q;
  logic rx_er_seen_q;
  logic late_col_q;
  logic wdog_q;
  logic [31:0] word_d;
  logic keep_d;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      RSW_IDLE:
      begin
        if (!receive_enable_bit)
          state_d = RSW_HALT; // R19
        else if (frm_start)
          state_d = RSW_RECV;
      end
      RSW_RECV:
      begin
        // frame in progress is completed even if enable drops
        if (frm_end)
          state_d = RSW_PUSH;
      end
      RSW_PUSH:
      begin
        state_d = RSW_IDLE;
      end
      RSW_HALT:
      begin
        // frames arriving while halted are ignored
        if (receive_enable_bit)
          state_d = RSW_IDLE; // R20
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_q <= RSW_IDLE;
    else
      state_q <= state_d;
  end

  // ******************************************************************
  // frame events
  // ******************************************************************
  logic frame_open_w;
  logic byte_in_w;
  logic frame_done_w;
  logic halt_entry_w;

  assign frame_open_w = state_q == RSW_IDLE && frm_start;
  assign byte_in_w = state_q == RSW_RECV && frm_byte_vld;
  assign frame_done_w = state_q == RSW_RECV && frm_end;
  // halt is entered only from idle, so a running frame is never cut
  assign halt_entry_w = state_q != RSW_HALT && state_d == RSW_HALT; // R19

  // ******************************************************************
  // byte counting, never truncated
  // ******************************************************************
  // count saturates so a runaway frame cannot wrap to a short length
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cnt_q <= '0;
    else if (frame_open_w)
      cnt_q <= '0;
    else if (byte_in_w && cnt_q != '1)
      cnt_q <= cnt_q + 14'h0001; // R10
  end

  // ******************************************************************
  // header capture
  // ******************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      lt_q <= '0;
    end
    else if (state_q == RSW_IDLE && frm_start)
    begin
      lt_q <= '0;
    end
    else if (state_q == RSW_RECV && frm_byte_vld)
    begin
      if (cnt_q == LT_HI)
        lt_q[15:8] <= frm_byte;
      if (cnt_q == LT_LO)
        lt_q[7:0] <= frm_byte;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      da_bcast_q <= 1'b0;
      da_mcast_q <= 1'b0;
    end
    else if (state_q == RSW_IDLE && frm_start)
    begin
      da_bcast_q <= 1'b1;
      da_mcast_q <= 1'b0;
    end
    else if (state_q == RSW_RECV && frm_byte_vld && cnt_q <= DA_LAST)
    begin
      if (frm_byte != BCAST_BYTE)
        da_bcast_q <= 1'b0; // R5
      if (cnt_q == '0)
        da_mcast_q <= frm_byte[0]; // R9
    end
  end

  // ******************************************************************
  // in-frame error tracking
  // ******************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rx_er_seen_q <= 1'b0;
    else if (frame_open_w)
      rx_er_seen_q <= mii_rx_er;
    else if (state_q == RSW_RECV && mii_rx_er)
      rx_er_seen_q <= 1'b1; // R14
  end

  // only collisions past the collision window are late
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      late_col_q <= 1'b0;
    else if (frame_open_w)
      late_col_q <= 1'b0;
    else if (state_q == RSW_RECV && mii_col && cnt_q >= COL_WINDOW)
      late_col_q <= 1'b1; // R11
  end

  // watchdog only flags; the frame is never cut
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      wdog_q <= 1'b0;
    else if (frame_open_w)
      wdog_q <= 1'b0;
    else if (byte_in_w && cnt_q >= WDOG_CNT)
      wdog_q <= 1'b1; // R13
  end

  // ******************************************************************
  // frame classification at frame end
  // ******************************************************************
  logic runt_w;
  logic too_long_w;
  logic late_w;
  logic len_bad_w;
  logic drib_w;
  logic crc_bad_w;
  logic mii_err_w;
  logic bcast_w;
  logic eth_type_w;
  logic [13:0] expect_len_w;

  // a collision in the end cycle still belongs to the frame
  assign late_w = late_col_q || (mii_col && cnt_q >= COL_WINDOW); // R11
  assign mii_err_w = rx_er_seen_q || mii_rx_er; // R14
  assign runt_w = cnt_q < COL_WINDOW; // R7
  assign too_long_w = cnt_q > MAX_FRAME; // R10
  assign bcast_w = da_bcast_q && cnt_q > DA_LAST; // R5
  assign eth_type_w = (cnt_q >= HDR_BYTES) && (lt_q > MAX_LEN_FIELD); // R12
  // still produced for runt, late and watchdog frames; meaningless there
  assign crc_bad_w = !frm_crc_ok || mii_err_w; // R17
  assign keep_d = !runt_w || pass_bad_frames; // R8

  // short payloads are padded to the minimum frame
  always_comb
  begin
    if (lt_q < MIN_PAYLOAD)
      expect_len_w = COL_WINDOW;
    else
      expect_len_w = lt_q[13:0] + OVERHEAD;
  end

  assign len_bad_w = (cnt_q >= HDR_BYTES) && (lt_q <= MAX_LEN_FIELD)
    && (cnt_q != expect_len_w); // R6

  always_comb
  begin
    if (mode_10m)
      drib_w = frm_dribble_bits >= DRIB_10M; // R15
    else
      drib_w = frm_dribble_bits == DRIB_MII; // R15
  end

  // ******************************************************************
  // status word assembly
  // ******************************************************************
  always_comb
  begin
    word_d = ST_RESET; // R1
    word_d[ST_FILTER_FAIL] = frm_filter_fail; // R2
    word_d[ST_LEN_LO +: LEN_W] = cnt_q; // R3
    word_d[ST_ERR_SUM] = runt_w || too_long_w || late_w || crc_bad_w; // R4
    word_d[ST_BCAST] = bcast_w; // R5
    word_d[ST_LEN_MISMATCH] = len_bad_w; // R6
    word_d[ST_RUNT] = runt_w; // R7
    word_d[ST_MCAST] = da_mcast_q; // R9
    word_d[ST_TOO_LONG] = too_long_w; // R10
    word_d[ST_LATE_COL] = late_w; // R11
    word_d[ST_ETH_TYPE] = eth_type_w; // R12
    word_d[ST_WDOG] = wdog_q; // R13
    word_d[ST_MII_ERR] = mii_err_w; // R14
    word_d[ST_DRIBBLE] = drib_w && !late_w; // R16
    word_d[ST_CRC_ERR] = crc_bad_w; // R17
  end

  // ******************************************************************
  // status output
  // ******************************************************************
  // word is refreshed even for a discarded runt
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      status_word_q <= ST_RESET;
    else if (frame_done_w)
      status_word_q <= word_d;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      status_push_q <= 1'b0;
    else
      status_push_q <= frame_done_w && keep_d; // R8
  end

  // ******************************************************************
  // receiver halt and restart
  // ******************************************************************
  // follows the next state so it drops together with the pulse
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      receiver_on_q <= 1'b0;
    else
      receiver_on_q <= state_d != RSW_HALT;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      receiver_halted_pulse_q <= 1'b0;
    else
      receiver_halted_pulse_q <= halt_entry_w; // R19
  end

  // ******************************************************************
  // receive error flag, set wins over clear
  // ******************************************************************
  logic data_underrun_w;
  logic status_underrun_w;
  logic status_overrun_w;

  assign data_underrun_w = host_data_rd && data_fifo_empty; // R21
  assign status_underrun_w = host_status_rd && status_fifo_empty; // R21
  assign status_overrun_w = status_push_q && status_fifo_full; // R21

  // reception carries on; only the host clears the flag
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      receive_error_flag_q <= 1'b0;
    else if (data_underrun_w || status_underrun_w || status_overrun_w)
      receive_error_flag_q <= 1'b1; // R21
    else if (error_flag_clr)
      receive_error_flag_q <= 1'b0;
  end

endmodule // rsw_rx_status

/* File: sim/rsw_rx_status_assertions.sv */
`timescale 1ns/1ns
module rsw_rx_status_assertions
  import rsw_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // controls
  input wire logic receive_enable_bit,
  input wire logic pass_bad_frames,
  input wire logic host_data_rd,
  input wire logic data_fifo_empty,
  input wire logic status_fifo_full,
  input wire logic error_flag_clr,
  // outputs
  input wire logic [31:0] status_word_q,
  input wire logic status_push_q,
  input wire logic receiver_on_q,
  input wire logic receiver_halted_pulse_q,
  input wire logic receive_error_flag_q
);
  // ******
  // checks
  // ******
  logic [13:0] len;
  assign len = status_word_q[29:16];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_RSVD: assert property (status_push_q |->
    (status_word_q & 32'h8000_4301) == 32'h0) else $error("reserved bit set");
  AST_SUM: assert property (status_push_q |->
    status_word_q[15] == |(status_word_q & 32'h0000_08c2)) else $error("summary bit wrong");
  AST_RUNT: assert property (status_push_q |-> status_word_q[11] == (len < COL_WINDOW))
    else $error("runt bit wrong");
  AST_PASS: assert property (status_push_q && status_word_q[11] |-> $past(pass_bad_frames))
    else $error("runt pushed");
  AST_LONG: assert property (status_push_q |-> status_word_q[7] == (len > MAX_FRAME))
    else $error("too long bit wrong");
  AST_TYPE: assert property (status_push_q && len < HDR_BYTES |-> !status_word_q[5])
    else $error("type bit on short frame");
  AST_DRIB: assert property (status_push_q && status_word_q[6] |-> !status_word_q[2])
    else $error("dribble with collision");
  AST_HALT: assert property ($rose(receiver_halted_pulse_q) |->
    !receiver_on_q && !$past(receive_enable_bit) ##1 !receiver_halted_pulse_q)
    else $error("halt pulse wrong");
  AST_ON: assert property (receive_enable_bit && receiver_on_q |=> receiver_on_q)
    else $error("receiver stopped");
  AST_UNDER: assert property (host_data_rd && data_fifo_empty |=> receive_error_flag_q)
    else $error("underrun missed");
  AST_OVER: assert property (status_push_q && status_fifo_full |=> receive_error_flag_q)
    else $error("overrun missed");
  AST_STICKY: assert property (receive_error_flag_q && !error_flag_clr |=>
    receive_error_flag_q) else $error("error flag lost");
  cover property (status_push_q && status_word_q[11]);
  cover property (receiver_halted_pulse_q);
  cover property (status_push_q && status_fifo_full);
endmodule // rsw_rx_status_assertions
bind rsw_rx_status rsw_rx_status_assertions chk_u (.sys_clk, .rst, .receive_enable_bit,
  .pass_bad_frames, .host_data_rd, .data_fifo_empty, .status_fifo_full, .error_flag_clr,
  .status_word_q, .status_push_q, .receiver_on_q, .receiver_halted_pulse_q,
  .receive_error_flag_q);

/* File: sim/rsw_host_model.sv */
`timescale 1ns/1ns
module rsw_host_model
  import rsw_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // scenario controls
  input wire logic halt_req,
  input wire logic drain,
  // device side
  input wire logic status_push_q,
  output logic receive_enable_bit,
  output logic host_status_rd,
  output logic status_fifo_empty,
  output logic status_fifo_full
);
  // ****************************
  // two-entry status fifo model
  // ****************************
  logic [1:0] cnt_q = 2'h0;
  assign receive_enable_bit = !halt_req;
  assign host_status_rd = drain;
  assign status_fifo_empty = cnt_q == 2'h0;
  assign status_fifo_full = cnt_q == 2'h2;
  // soft reset empties the fifos as well
  always @(posedge sys_clk)
    if (rst)
      cnt_q <= 2'h0;
    else
      cnt_q <= cnt_q + 2'(status_push_q & !status_fifo_full) - 2'(drain & !status_fifo_empty);
endmodule // rsw_host_model

/* File: sim/rx_status_word_and_receiver_control_tb.sv */
`timescale 1ns/1ns
module rx_status_word_and_receiver_control_tb
  import rsw_pkg::*;
;
  logic sys_clk, rst, receive_enable_bit, pass_bad_frames, mode_10m, frm_start, frm_byte_vld;
  logic frm_end, frm_crc_ok, frm_filter_fail, mii_rx_er, mii_col, host_data_rd, host_status_rd;
  logic status_fifo_empty, status_fifo_full, error_flag_clr, status_push_q, receiver_on_q;
  logic receiver_halted_pulse_q, receive_error_flag_q, halt_req, drain, data_fifo_empty;
  logic [7:0] frm_byte;
  logic [2:0] frm_dribble_bits;
  logic [31:0] status_word_q;
  logic [31:0] e;
  logic [31:0] exp_q[$];
  int n_mismatch = 0;
  int comparisons = 0;
  rsw_rx_status dut_u (.sys_clk, .rst, .receive_enable_bit, .pass_bad_frames, .mode_10m,
    .frm_start, .frm_byte_vld, .frm_byte, .frm_end, .frm_dribble_bits, .frm_crc_ok,
    .frm_filter_fail, .mii_rx_er, .mii_col, .host_data_rd, .data_fifo_empty,
    .host_status_rd, .status_fifo_empty, .status_fifo_full, .error_flag_clr, .status_word_q,
    .status_push_q, .receiver_on_q, .receiver_halted_pulse_q, .receive_error_flag_q);
  rsw_host_model host_u (.sys_clk, .rst, .halt_req, .drain, .status_push_q, .receive_enable_bit,
    .host_status_rd, .status_fifo_empty, .status_fifo_full);
  // *****
  // tasks
  // *****
  task automatic check(string what, logic [31:0] want, logic [31:0] got);
    comparisons++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, want, got);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // flags: enable, crc ok, filter fail, rx error, collision at end
  task automatic frame(logic [13:0] len, logic [7:0] da, logic [15:0] lt, logic [2:0] dr,
    logic [4:0] fl);
    logic rn, lg, lc, bc, le, et, db, er;
    rn = len < COL_WINDOW;
    lg = len > MAX_FRAME;
    lc = fl[0] && !rn;
    er = fl[1];
    bc = len > DA_LAST && da == BCAST_BYTE;
    le = lt <= MAX_LEN_FIELD && len >= HDR_BYTES
      && len != (lt < MIN_PAYLOAD ? COL_WINDOW : lt[13:0] + OVERHEAD);
    et = len >= HDR_BYTES && lt > MAX_LEN_FIELD;
    db = (mode_10m ? dr >= DRIB_10M : dr == DRIB_MII) && !lc;
    if (fl[4] && (!rn || pass_bad_frames))
      exp_q.push_back({1'h0, fl[2], len, rn | lg | lc | !fl[3] | er, 1'h0, bc, le, rn,
        da[0], 2'h0, lg, lc, et, len > 14'h0800, er, db, !fl[3] | er, 1'h0});
    frm_start = 1'h1;
    @(negedge sys_clk);
    frm_start = 1'h0;
    for (int i = 0; i < len; i++)
    begin
      frm_byte_vld = 1'h1;
      frm_byte = i < 6 ? da : i == 12 ? lt[15:8] : i == 13 ? lt[7:0] : 8'($urandom);
      @(negedge sys_clk);
    end
    {frm_byte_vld, frm_end, frm_dribble_bits, frm_crc_ok, frm_filter_fail, mii_rx_er,
      mii_col} = {2'h1, dr, fl[3:0]};
    @(negedge sys_clk);
    {frm_end, mii_rx_er, mii_col} = 3'h0;
    @(negedge sys_clk);
  endtask
  // **********************
  // clock, watchdog, monitor
  // **********************
  initial
  begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial
  begin
    #200000;
    n_mismatch++;
    summarize();
  end
  always @(negedge sys_clk)
    if (!rst && status_push_q === 1'h1)
    begin
      e = exp_q.size() != 0 ? exp_q.pop_front() : 32'hffff_ffff;
      check("status word", e, status_word_q);
    end
  // *********
  // scenarios
  // *********
  initial
  begin
    {pass_bad_frames, mode_10m, frm_start, frm_byte_vld, frm_byte, frm_end, frm_dribble_bits,
      frm_crc_ok, frm_filter_fail, mii_rx_er, mii_col, host_data_rd, error_flag_clr,
      data_fifo_empty} = '0;
    {halt_req, drain} = 2'h0;
    rst = 1'h1;
    void'($urandom(72603));
    repeat (10) @(negedge sys_clk);
    rst = 1'h0;
    frame(14'h0064, 8'hff, 16'h0052, 3'h4, 5'h18);
    frame(14'h0064, 8'h01, 16'h0032, 3'h0, 5'h10);
    frame(14'h0050, 8'h00, 16'h0800, 3'h4, 5'h19);
    check("overrun flag", 32'h1, 32'(receive_error_flag_q));
    error_flag_clr = 1'h1;
    @(negedge sys_clk);
    {error_flag_clr, drain} = 2'h1;
    check("cleared flag", 32'h0, 32'(receive_error_flag_q));
    repeat (3) @(negedge sys_clk);
    drain = 1'h0;
    check("status underrun flag", 32'h1, 32'(receive_error_flag_q));
    frame(14'h0640, 8'h00, 16'h0800, 3'h0, 5'h18);
    frame(14'h0834, 8'h00, 16'h0800, 3'h0, 5'h1c);
    frame(14'h0064, 8'h00, 16'h0010, 3'h0, 5'h1a);
    rst = 1'h1;
    @(negedge sys_clk);
    rst = 1'h0;
    check("flag after reset", 32'h0, 32'(receive_error_flag_q));
    host_data_rd = 1'h1;
    @(negedge sys_clk);
    check("read with data", 32'h0, 32'(receive_error_flag_q));
    data_fifo_empty = 1'h1;
    @(negedge sys_clk);
    host_data_rd = 1'h0;
    @(negedge sys_clk);
    check("data underrun flag", 32'h1, 32'(receive_error_flag_q));
    halt_req = 1'h1;
    for (int k = 0; k < 20 && receiver_halted_pulse_q !== 1'h1; k++)
      @(negedge sys_clk);
    check("halt pulse", 32'h1, 32'(receiver_halted_pulse_q));
    check("receiver off", 32'h0, 32'(receiver_on_q));
    @(negedge sys_clk);
    check("halt pulse width", 32'h0, 32'(receiver_halted_pulse_q));
    frame(14'h0064, 8'h00, 16'h0052, 3'h0, 5'h08);
    halt_req = 1'h0;
    repeat (2) @(negedge sys_clk);
    check("receiver on", 32'h1, 32'(receiver_on_q));
    frame(14'h000c, 8'h00, 16'h0000, 3'h0, 5'h18);
    pass_bad_frames = 1'h1;
    frame(14'h000c, 8'hff, 16'h0800, 3'h0, 5'h18);
    mode_10m = 1'h1;
    frame(14'h0064, 8'h00, 16'h0052, 3'h3, 5'h18);
    repeat (5) @(negedge sys_clk);
    check("pending words", 32'h0, 32'(exp_q.size()));
    summarize();
  end
endmodule // rx_status_word_and_receiver_control_tb
